// ### src/bls_pkg.sv
// Shared constants, types and register map of the link mode sequencer.
package bls_pkg;

  // Register word offsets on the Avalon-MM word address.
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h1;
  localparam logic [3:0] REG_RF = 4'h2;
  localparam logic [3:0] REG_RETRY = 4'h3;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_IRQ_STS = 4'h5;
  localparam logic [3:0] REG_IRQ_MSK = 4'h6;
  localparam logic [3:0] REG_RSSI = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // Field positions.
  localparam int CFG_AUTO_ACK_BIT = 0;
  localparam int CFG_RATE_BIT = 1;
  localparam int CFG_BURST_LSB = 4;
  localparam int RF_CHAN_LSB = 0;
  localparam int RF_POWER_LSB = 8;
  localparam int RSSI_START_BIT = 0;
  localparam int RSSI_MODE_BIT = 1;
  localparam int RSSI_BUSY_BIT = 8;
  localparam int RSSI_MODE_RD_BIT = 9;

  // Interrupt status and mask bits.
  localparam int IRQ_W = 6;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_OK = 1;
  localparam int IRQ_RX_BAD = 2;
  localparam int IRQ_MAX_RETRY = 3;
  localparam int IRQ_RSSI_DONE = 4;
  localparam int IRQ_WAKE = 5;

  // Packet information flag bits.
  localparam int FLAG_ACK_REQ = 0;
  localparam int FLAG_IS_ACK = 1;
  localparam int FLAG_ERR = 2;

  // Mode command codes written to the mode register.
  localparam logic [2:0] MODE_STBY = 3'h0;
  localparam logic [2:0] MODE_TX = 3'h1;
  localparam logic [2:0] MODE_RX = 3'h2;
  localparam logic [2:0] MODE_LP = 3'h3;
  localparam logic [2:0] MODE_DEEP = 3'h4;

  // Reset values.
  localparam logic [31:0] CONFIG_RST = 32'h00000011;
  localparam logic [31:0] RF_RST = 32'h00000000;
  localparam logic [31:0] RETRY_RST = 32'h00000003;
  localparam logic [7:0] ADDR_RST = 8'h00;

  // Radio figures.
  localparam logic [5:0] NUM_CHANNELS = 6'h28;
  localparam logic [7:0] BT_X100 = 8'h32;
  localparam logic [7:0] MOD_IDX_1M_X100 = 8'h32;
  localparam logic [7:0] MOD_IDX_2M_X100 = 8'h20;

  // Timing: times in microseconds, counts derived from the clock rate.
  localparam int CLK_MHZ = 200;
  localparam int ACK_TIMEOUT_US = 250;
  localparam int WAKE_LP_US = 10;
  localparam int WAKE_DEEP_US = 150;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * CLK_MHZ;
  localparam int WAKE_LP_CYC = WAKE_LP_US * CLK_MHZ;
  localparam int WAKE_DEEP_CYC = WAKE_DEEP_US * CLK_MHZ;

  // Check value generator.
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  typedef enum logic [2:0] {
    ST_STBY = 3'b000,
    ST_TX = 3'b001,
    ST_ACKWAIT = 3'b011,
    ST_RX = 3'b010,
    ST_RXACK = 3'b110,
    ST_LP = 3'b111,
    ST_DEEP = 3'b101,
    ST_WAKE = 3'b100
  } bls_state_type;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } bls_rx_byte_type;

  typedef struct packed {
    logic valid;
    logic addr_ok;
    logic crc_ok;
    logic [7:0] flags;
  } bls_rx_result_type;

  typedef struct packed {
    logic [5:0] channel;
    logic rate_2m;
    logic [2:0] power;
    logic [7:0] mod_index;
    logic [7:0] bt;
  } bls_rf_type;

endpackage

// ### src/bls_rx_check.sv
// Received packet checker: address match, flag capture and check value test.
module bls_rx_check
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] own_addr_in,
  input wire bls_pkg::bls_rx_byte_type byte_in,
  output bls_pkg::bls_rx_result_type result_out
);

  logic [15:0] crc;
  logic [1:0] pos;
  logic addr_ok;
  logic [7:0] flags;
  logic [15:0] next_crc;

  // One byte step of the check value, MSB first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      r = r[15] ? ((r << 1) ^ bls_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // The check value runs over the whole packet, received check bytes included.
  always_comb
  begin
    next_crc = crc_step(byte_in.first ? bls_pkg::CRC_INIT : crc, byte_in.data);
  end

  // Byte position: first byte is the address, second the flag byte.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      crc <= bls_pkg::CRC_INIT;
      pos <= 2'h0;
      addr_ok <= 1'b0;
      flags <= 8'h00;
    end
    else if (ce_in && byte_in.valid)
    begin
      crc <= next_crc;
      if (byte_in.first)
      begin
        addr_ok <= (byte_in.data == own_addr_in);
        pos <= 2'h1;
      end
      else if (pos == 2'h1)
      begin
        flags <= byte_in.data;
        pos <= 2'h2;
      end
    end
  end

  // Verdict pulse on the last byte; a zero residue means the value matched.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      result_out <= '0;
    end
    else if (ce_in)
    begin
      result_out.valid <= byte_in.valid && byte_in.last;
      if (byte_in.valid && byte_in.last)
      begin
        result_out.crc_ok <= (next_crc == 16'h0000);
        result_out.addr_ok <= byte_in.first ? (byte_in.data == own_addr_in) : addr_ok;
        result_out.flags <= (pos == 2'h1) ? byte_in.data : flags;
      end
    end
  end

endmodule

// ### src/bls_sequencer.sv
// Link mode sequencer: mode control, auto acknowledge, retransmit and registers.
// How it works
// - Auto-ack: send, await ack, then standby.
// - Retransmit on error ack or none.
// - No auto-ack: send then straight standby.
// - Programmable burst of several packets.
// - Receive on selected channel and rate.
// - Check address, flags and check value.
// - Auto-ack receive: answer ack, back to receive.
// - Receive lasts until host commands standby.
// - Quick sleep entry; deep wake takes longer.
// - Data rate selectable, one or two Mbps.
// - Forty selectable channels.
// - Eight transmit power levels.
// - BT one half; index by rate.
// - External power amplifier control output.
// - Single-shot signal strength readable when done.
// - Maskable interrupt output for status events.
// - Register access over the host bus.
//
// Chosen here: the address map and the Avalon-MM register port.
module bls_sequencer
#(
  parameter int ACK_TIMEOUT_CYC = bls_pkg::ACK_TIMEOUT_CYC,
  parameter int WAKE_DEEP_CYC = bls_pkg::WAKE_DEEP_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  output logic tx_start_out,
  output logic tx_is_ack_out,
  input wire logic tx_done_in,
  input wire bls_pkg::bls_rx_byte_type rx_byte_in,
  output logic rx_en_out,
  output logic pa_en_out,
  output logic [1:0] sleep_out,
  output bls_pkg::bls_rf_type rf_out,
  output logic rssi_start_out,
  output logic rssi_mode_out,
  input wire logic rssi_done_in,
  input wire logic [7:0] rssi_value_in
);

  bls_pkg::bls_state_type state;
  bls_pkg::bls_rx_result_type rx_res;
  logic [31:0] cfg;
  logic [31:0] rf_reg;
  logic [31:0] retry_cfg;
  logic [7:0] own_addr;
  logic [bls_pkg::IRQ_W-1:0] irq_sts;
  logic [bls_pkg::IRQ_W-1:0] irq_msk;
  logic [bls_pkg::IRQ_W-1:0] events;
  logic [4:0] fsm_ev;
  logic rssi_ev;
  logic [7:0] rssi_value;
  logic rssi_busy;
  logic rssi_mode;
  logic cmd_valid;
  logic [2:0] cmd_code;
  logic [31:0] cnt;
  logic [3:0] retries;
  logic [3:0] burst_left;
  logic wr_take;
  logic rd_take;
  logic auto_ack;
  logic ack_good;
  logic ack_bad;
  logic [3:0] burst_cfg;

  // Merge write data into a register under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // A request is taken at the edge where waitrequest is still high.
  assign wr_take = avs_write_in && avs_waitrequest_out;
  assign rd_take = avs_read_in && avs_waitrequest_out;
  assign auto_ack = cfg[bls_pkg::CFG_AUTO_ACK_BIT];
  assign burst_cfg = cfg[bls_pkg::CFG_BURST_LSB +: 4];
  assign ack_good = rx_res.valid && rx_res.addr_ok && rx_res.crc_ok
                    && rx_res.flags[bls_pkg::FLAG_IS_ACK] && !rx_res.flags[bls_pkg::FLAG_ERR];
  assign ack_bad = rx_res.valid && rx_res.addr_ok && rx_res.crc_ok
                   && rx_res.flags[bls_pkg::FLAG_IS_ACK] && rx_res.flags[bls_pkg::FLAG_ERR];
  // Sequencer events 0 to 3 keep their status bit positions; the wake event sits above the measure event.
  assign events = {fsm_ev[4], rssi_ev, fsm_ev[3:0]};

  bls_rx_check u_check
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .own_addr_in(own_addr),
    .byte_in(rx_byte_in),
    .result_out(rx_res)
  );

  // Bus handshake with one wait cycle.
  // Waitrequest idles high so that every access sees the same fixed latency.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      avs_waitrequest_out <= 1'b1;
    end
    else if (ce_in)
    begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    end
  end

  // Read data mux.
  // Unmapped words read as zero.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      avs_readdata_out <= 32'h00000000;
    end
    else if (ce_in && rd_take)
    begin
      case (avs_address_in)
        bls_pkg::REG_MODE: avs_readdata_out <= {29'h0, state};
        bls_pkg::REG_CONFIG: avs_readdata_out <= cfg;
        bls_pkg::REG_RF: avs_readdata_out <= rf_reg;
        bls_pkg::REG_RETRY: avs_readdata_out <= retry_cfg;
        bls_pkg::REG_ADDR: avs_readdata_out <= {24'h0, own_addr};
        bls_pkg::REG_IRQ_STS: avs_readdata_out <= {26'h0, irq_sts};
        bls_pkg::REG_IRQ_MSK: avs_readdata_out <= {26'h0, irq_msk};
        bls_pkg::REG_RSSI: avs_readdata_out <= {22'h0, rssi_mode, rssi_busy, rssi_value};
        bls_pkg::REG_STATUS: avs_readdata_out <= {24'h0, burst_left, retries};
        default: avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cfg <= bls_pkg::CONFIG_RST;
      rf_reg <= bls_pkg::RF_RST;
      retry_cfg <= bls_pkg::RETRY_RST;
      own_addr <= bls_pkg::ADDR_RST;
      irq_msk <= '0;
    end
    else if (ce_in && wr_take)
    begin
      case (avs_address_in)
        bls_pkg::REG_CONFIG: cfg <= be_merge(cfg, avs_writedata_in, avs_byteenable_in);
        bls_pkg::REG_RF: rf_reg <= be_merge(rf_reg, avs_writedata_in, avs_byteenable_in);
        bls_pkg::REG_RETRY: retry_cfg <= be_merge(retry_cfg, avs_writedata_in, avs_byteenable_in);
        bls_pkg::REG_ADDR:
        begin
          if (avs_byteenable_in[0])
          begin
            own_addr <= avs_writedata_in[7:0];
          end
        end
        bls_pkg::REG_IRQ_MSK:
        begin
          if (avs_byteenable_in[0])
          begin
            irq_msk <= avs_writedata_in[bls_pkg::IRQ_W-1:0];
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // Mode command strobe, one cycle per write to the mode register.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cmd_valid <= 1'b0;
      cmd_code <= bls_pkg::MODE_STBY;
    end
    else if (ce_in)
    begin
      cmd_valid <= wr_take && avs_byteenable_in[0] && (avs_address_in == bls_pkg::REG_MODE);
      cmd_code <= avs_writedata_in[2:0];
    end
  end

  // Sticky status, set wins over clear.
  // A one written to a status bit clears it unless an event hits the same cycle.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      irq_sts <= '0;
      irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_take && avs_byteenable_in[0] && (avs_address_in == bls_pkg::REG_IRQ_STS))
      begin
        irq_sts <= (irq_sts & ~avs_writedata_in[bls_pkg::IRQ_W-1:0]) | events;
      end
      else
      begin
        irq_sts <= irq_sts | events;
      end
      irq_out <= |(irq_sts & irq_msk);
    end
  end

  // Single-shot signal strength measurement.
  // Busy stays high until the result is latched, so a read of the value is safe once clear.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rssi_start_out <= 1'b0;
      rssi_busy <= 1'b0;
      rssi_mode <= 1'b0;
      rssi_value <= 8'h00;
      rssi_ev <= 1'b0;
    end
    else if (ce_in)
    begin
      rssi_start_out <= 1'b0;
      rssi_ev <= 1'b0;
      if (rssi_busy && rssi_done_in)
      begin
        rssi_value <= rssi_value_in;
        rssi_busy <= 1'b0;
        rssi_ev <= 1'b1;
      end
      else if (!rssi_busy && wr_take && avs_byteenable_in[0]
               && (avs_address_in == bls_pkg::REG_RSSI)
               && avs_writedata_in[bls_pkg::RSSI_START_BIT])
      begin
        rssi_mode <= avs_writedata_in[bls_pkg::RSSI_MODE_BIT];
        rssi_busy <= 1'b1;
        rssi_start_out <= 1'b1;
      end
    end
  end

  // Main mode sequencer.
  // Retry and burst counts are four bits; a burst setting of zero sends one packet.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= bls_pkg::ST_STBY;
      cnt <= 32'h00000000;
      retries <= 4'h0;
      burst_left <= 4'h0;
      tx_start_out <= 1'b0;
      tx_is_ack_out <= 1'b0;
      fsm_ev <= 5'h00;
    end
    else if (ce_in)
    begin
      tx_start_out <= 1'b0;
      fsm_ev <= 5'h00;
      case (state)
        bls_pkg::ST_STBY:
        begin
          if (cmd_valid)
          begin
            case (cmd_code)
              bls_pkg::MODE_TX:
              begin
                burst_left <= (burst_cfg == 4'h0) ? 4'h1 : burst_cfg;
                retries <= 4'h0;
                tx_is_ack_out <= 1'b0;
                tx_start_out <= 1'b1;
                state <= bls_pkg::ST_TX;
              end
              bls_pkg::MODE_RX: state <= bls_pkg::ST_RX;
              bls_pkg::MODE_LP: state <= bls_pkg::ST_LP;
              bls_pkg::MODE_DEEP: state <= bls_pkg::ST_DEEP;
              default: state <= bls_pkg::ST_STBY;
            endcase
          end
        end
        bls_pkg::ST_TX:
        begin
          if (cmd_valid && cmd_code == bls_pkg::MODE_STBY)
          begin
            state <= bls_pkg::ST_STBY;
          end
          else if (tx_done_in)
          begin
            if (auto_ack)
            begin
              cnt <= 32'h00000000;
              state <= bls_pkg::ST_ACKWAIT;
            end
            else
            begin
              fsm_ev[bls_pkg::IRQ_TX_DONE] <= 1'b1;
              if (burst_left > 4'h1)
              begin
                burst_left <= burst_left - 4'h1;
                tx_start_out <= 1'b1;
              end
              else
              begin
                burst_left <= 4'h0;
                state <= bls_pkg::ST_STBY;
              end
            end
          end
        end
        bls_pkg::ST_ACKWAIT:
        begin
          cnt <= cnt + 32'h00000001;
          if (cmd_valid && cmd_code == bls_pkg::MODE_STBY)
          begin
            state <= bls_pkg::ST_STBY;
          end
          else if (ack_good)
          begin
            fsm_ev[bls_pkg::IRQ_TX_DONE] <= 1'b1;
            retries <= 4'h0;
            if (burst_left > 4'h1)
            begin
              burst_left <= burst_left - 4'h1;
              tx_start_out <= 1'b1;
              state <= bls_pkg::ST_TX;
            end
            else
            begin
              burst_left <= 4'h0;
              state <= bls_pkg::ST_STBY;
            end
          end
          else if (ack_bad || cnt >= 32'(ACK_TIMEOUT_CYC - 1))
          begin
            if (retries >= retry_cfg[3:0])
            begin
              fsm_ev[bls_pkg::IRQ_MAX_RETRY] <= 1'b1;
              state <= bls_pkg::ST_STBY;
            end
            else
            begin
              retries <= retries + 4'h1;
              tx_start_out <= 1'b1;
              state <= bls_pkg::ST_TX;
            end
          end
        end
        bls_pkg::ST_RX:
        begin
          // Only a standby command ends receive.
          if (cmd_valid && cmd_code == bls_pkg::MODE_STBY)
          begin
            state <= bls_pkg::ST_STBY;
          end
          else if (rx_res.valid)
          begin
            if (rx_res.addr_ok && rx_res.crc_ok && !rx_res.flags[bls_pkg::FLAG_IS_ACK])
            begin
              fsm_ev[bls_pkg::IRQ_RX_OK] <= 1'b1;
              if (auto_ack && rx_res.flags[bls_pkg::FLAG_ACK_REQ])
              begin
                tx_is_ack_out <= 1'b1;
                tx_start_out <= 1'b1;
                state <= bls_pkg::ST_RXACK;
              end
            end
            else if (rx_res.addr_ok)
            begin
              fsm_ev[bls_pkg::IRQ_RX_BAD] <= 1'b1;
            end
          end
        end
        bls_pkg::ST_RXACK:
        begin
          if (tx_done_in)
          begin
            tx_is_ack_out <= 1'b0;
            state <= bls_pkg::ST_RX;
          end
        end
        bls_pkg::ST_LP, bls_pkg::ST_DEEP:
        begin
          if (cmd_valid && cmd_code == bls_pkg::MODE_STBY)
          begin
            cnt <= (state == bls_pkg::ST_DEEP) ? 32'(WAKE_DEEP_CYC) : 32'(bls_pkg::WAKE_LP_CYC);
            state <= bls_pkg::ST_WAKE;
          end
        end
        bls_pkg::ST_WAKE:
        begin
          cnt <= cnt - 32'h00000001;
          if (cnt <= 32'h00000001)
          begin
            fsm_ev[4] <= 1'b1;
            state <= bls_pkg::ST_STBY;
          end
        end
        default: state <= bls_pkg::ST_STBY;
      endcase
    end
  end

  // Radio front-end controls follow the state one cycle later.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pa_en_out <= 1'b0;
      rx_en_out <= 1'b0;
      sleep_out <= 2'h0;
    end
    else if (ce_in)
    begin
      pa_en_out <= (state == bls_pkg::ST_TX) || (state == bls_pkg::ST_RXACK);
      rx_en_out <= (state == bls_pkg::ST_RX) || (state == bls_pkg::ST_ACKWAIT);
      sleep_out <= (state == bls_pkg::ST_DEEP) ? 2'h2 : ((state == bls_pkg::ST_LP) ? 2'h1 : 2'h0);
    end
  end

  // Channel, rate, power and modulation settings for the modem.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rf_out <= '0;
      rssi_mode_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rf_out.channel <= (rf_reg[bls_pkg::RF_CHAN_LSB +: 6] < bls_pkg::NUM_CHANNELS)
                        ? rf_reg[bls_pkg::RF_CHAN_LSB +: 6] : bls_pkg::NUM_CHANNELS - 6'h01;
      rf_out.rate_2m <= cfg[bls_pkg::CFG_RATE_BIT];
      rf_out.power <= rf_reg[bls_pkg::RF_POWER_LSB +: 3];
      rf_out.mod_index <= cfg[bls_pkg::CFG_RATE_BIT] ? bls_pkg::MOD_IDX_2M_X100
                                                      : bls_pkg::MOD_IDX_1M_X100;
      rf_out.bt <= bls_pkg::BT_X100;
      rssi_mode_out <= rssi_mode;
    end
  end

endmodule

// ### tb/bls_seq_monitor.sv
// Port-level checks of the link mode sequencer.
module bls_seq_monitor
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic tx_start_out,
  input wire logic rx_en_out,
  input wire logic pa_en_out,
  input wire logic [1:0] sleep_out,
  input wire bls_pkg::bls_rf_type rf_out,
  input wire logic rssi_start_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // A request meets a waiting slave on a running clock.
  sequence s_take;
    (avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in;
  endsequence
  a_bus_answer: assert property (s_take |=> !avs_waitrequest_out)
    else $error("request not answered");
  a_wait_short: assert property (!avs_waitrequest_out && ce_in |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  a_data_hold: assert property (!(avs_read_in && avs_waitrequest_out) && ce_in
    |=> $stable(avs_readdata_out))
    else $error("read data moved");
  // The first edge after reset still sees the reset value of the register.
  a_index_rate: assert property (!$past(rst_in) |-> rf_out.bt == 8'h32 &&
    rf_out.mod_index == (rf_out.rate_2m ? 8'h20 : 8'h32))
    else $error("modulation figures wrong");
  a_chan_limit: assert property (rf_out.channel <= 6'h27)
    else $error("channel out of range");
  a_pa_follow: assert property (tx_start_out |=> pa_en_out)
    else $error("amplifier not on");
  a_start_pulse: assert property (tx_start_out |=> !tx_start_out)
    else $error("send start too long");
  a_sleep_quiet: assert property (sleep_out != 2'h0 |-> !pa_en_out && !rx_en_out)
    else $error("radio on in sleep");
  a_rssi_pulse: assert property (rssi_start_out |=> !rssi_start_out)
    else $error("measure start too long");
endmodule

bind bls_sequencer bls_seq_monitor mon_u
(
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .tx_start_out(tx_start_out),
  .rx_en_out(rx_en_out), .pa_en_out(pa_en_out), .sleep_out(sleep_out),
  .rf_out(rf_out), .rssi_start_out(rssi_start_out)
);

// ### tb/bls_modem_model.sv
// Behavioural modem on the air side: sends, measures and delivers frames.
module bls_modem_model
(
  input wire logic clk_in,
  input wire logic tx_start_in,
  input wire logic rssi_start_in,
  output logic tx_done_out = 1'b0,
  output logic rssi_done_out = 1'b0,
  output logic [7:0] rssi_value_out = 8'h00,
  output bls_pkg::bls_rx_byte_type rx_byte_out = '0
);
  localparam logic [7:0] LEVEL = 8'h5C;
  int cnt = 0;
  // Random airtime so the sequencer sees quick and slow completions alike.
  always @(posedge clk_in)
  begin
    cnt <= tx_start_in ? $urandom_range(30, 2) : (cnt > 0 ? cnt - 1 : 0);
    tx_done_out <= (cnt == 1);
    rssi_done_out <= rssi_start_in;
    rssi_value_out <= rssi_start_in ? LEVEL : 8'($urandom);
  end
  // Address, flags, then a check value over both, sent high byte first.
  task automatic send_frame(input logic [7:0] a, input logic [7:0] f);
    logic [15:0] c;
    logic [7:0] b [4];
    c = 16'hFFFF;
    b[0] = a;
    b[1] = f;
    for (int i = 0; i < 16; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i / 8][7 - i % 8]) ? 16'h1021 : 16'h0000);
    b[2] = c[15:8];
    b[3] = c[7:0];
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_in);
      rx_byte_out <= '{i < 4, i == 0, i == 3, (i < 4) ? b[i % 4] : 8'($urandom)};
    end
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench of the link mode sequencer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic ce = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, rdata;
  logic wreq, irq, txs, txa, txd, rxen, paen, rss, rsm, rsd;
  logic [1:0] slp;
  logic [7:0] rsv;
  bls_pkg::bls_rx_byte_type rxb;
  bls_pkg::bls_rf_type rf;
  int bad_count = 0;
  int n_tests = 0;
  int n_done = 0;
  int acks = 0;
  int m [16];
  int ch, pw, b;
  initial
    forever #2.5 clk_in = ~clk_in;
  bls_sequencer #(.ACK_TIMEOUT_CYC(40), .WAKE_DEEP_CYC(50)) dut_u
  (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .irq_out(irq), .tx_start_out(txs), .tx_is_ack_out(txa), .tx_done_in(txd),
    .rx_byte_in(rxb), .rx_en_out(rxen), .pa_en_out(paen), .sleep_out(slp),
    .rf_out(rf), .rssi_start_out(rss), .rssi_mode_out(rsm), .rssi_done_in(rsd),
    .rssi_value_in(rsv)
  );
  bls_modem_model modem_u
  (
    .clk_in(clk_in), .tx_start_in(txs), .rssi_start_in(rss), .tx_done_out(txd),
    .rssi_done_out(rsd), .rssi_value_out(rsv), .rx_byte_out(rxb)
  );
  // Tally of finished sends and of sends marked as acknowledge.
  always @(posedge clk_in)
  begin
    n_done <= n_done + (txd === 1'b1);
    acks <= acks + (txs === 1'b1 && txa === 1'b1);
  end
  task automatic report_and_stop(input int hung);
    bad_count += hung;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access held until waitrequest is seen low; read data taken at that edge.
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (int k = 0; wreq !== 1'b0; k++)
    begin
      if (k > 50)
        report_and_stop(1);
      @(posedge clk_in);
    end
    rdata = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic poll(input logic [3:0] a, input logic [31:0] mk, input logic [31:0] e);
    int k;
    bus(1'b0, a, 32'h0);
    for (k = 0; k < 300 && (rdata & mk) !== e; k++)
      bus(1'b0, a, 32'h0);
    if (k == 300)
      report_and_stop(1);
  endtask
  // Waits until a given count of sends has finished and the receiver listens.
  task automatic wait_rx(input int t);
    for (int k = 0; n_done < t || rxen !== 1'b1; k++)
    begin
      if (k > 400)
        report_and_stop(1);
      @(posedge clk_in);
    end
  endtask
  initial
  begin
    b = $urandom(27087);
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    m = '{1: 32'h11, 3: 32'h3, default: 0};
    // Reset values; places above the map read zero.
    foreach (m[i])
      if (i != 8)
      begin
        bus(1'b0, 4'(i), 32'h0);
        chk(rdata, m[i]);
      end
    // Random legal channels and levels; the last channel is out of range.
    for (int i = 0; i < 4; i++)
    begin
      ch = (i == 3) ? 63 : $urandom_range(39);
      pw = $urandom_range(7);
      bus(1'b1, 4'h2, 32'(pw * 256 + ch));
      bus(1'b1, 4'h1, 32'(i % 2 * 2));
      bus(1'b0, 4'h2, 32'h0);
      chk(rf.channel, (ch > 39) ? 39 : ch);
      chk(rf.power, pw);
      chk(rf.rate_2m, i % 2);
    end
    // Burst without acknowledge, then masking and clearing of the event.
    b = $urandom_range(3, 1);
    bus(1'b1, 4'h1, 32'(b * 16));
    bus(1'b1, 4'h6, 32'h3F);
    ch = n_done;
    bus(1'b1, 4'h0, 32'h1);
    poll(4'h0, 32'h7, 32'h0);
    chk(n_done - ch, b);
    repeat (2) @(posedge clk_in); // Status reaches the pin two edges after the event.
    chk(irq, 1);
    bus(1'b1, 4'h6, 32'h0);
    bus(1'b0, 4'h5, 32'h0);
    chk({irq, rdata[0]}, 1);
    bus(1'b1, 4'h5, 32'h3F);
    bus(1'b1, 4'h6, 32'h3F);
    chk(irq, 0);
    // Error ack forces a resend, a clean ack ends it; silence uses up retries.
    bus(1'b1, 4'h4, 32'hA5);
    bus(1'b1, 4'h3, 32'h1);
    bus(1'b1, 4'h1, 32'h11);
    ch = n_done;
    bus(1'b1, 4'h0, 32'h1);
    wait_rx(ch + 1);
    modem_u.send_frame(8'hA5, 8'h06);
    wait_rx(ch + 2);
    modem_u.send_frame(8'hA5, 8'h02);
    poll(4'h0, 32'h7, 32'h0);
    bus(1'b0, 4'h5, 32'h0);
    chk({31'(n_done - ch), rdata[3]}, 4);
    bus(1'b1, 4'h5, 32'h3F);
    bus(1'b1, 4'h0, 32'h1);
    poll(4'h5, 32'h8, 32'h8);
    chk(n_done - ch, 4);
    // A frame asking for reply is answered, then reception goes on.
    bus(1'b1, 4'h0, 32'h2);
    poll(4'h0, 32'h7, 32'h2);
    ch = acks;
    modem_u.send_frame(8'hA5, 8'h01);
    wait_rx(n_done + 1);
    bus(1'b0, 4'h5, 32'h0);
    chk({31'(acks - ch), rdata[1]}, 3);
    poll(4'h0, 32'h7, 32'h2);
    bus(1'b1, 4'h0, 32'h0);
    poll(4'h0, 32'h7, 32'h0);
    // Strength is read once busy has cleared.
    bus(1'b1, 4'h7, 32'h3);
    poll(4'h7, 32'h100, 32'h0);
    chk(rdata[9:0], 10'h25C);
    chk(rsm, 1);
    // Deep sleep, then a slow wake with its event.
    bus(1'b1, 4'h0, 32'h4);
    poll(4'h0, 32'h7, 32'h5);
    chk(slp, 2);
    // A low clock enable must hold the wake count where it stands.
    bus(1'b1, 4'h0, 32'h0);
    ce <= 1'b0;
    repeat (100) @(posedge clk_in);
    ce <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk(rdata[2:0], 4);
    poll(4'h0, 32'h7, 32'h0);
    bus(1'b0, 4'h5, 32'h0);
    chk(rdata[5], 1);
    report_and_stop(0);
  end
  initial
  begin
    repeat (60000) @(posedge clk_in);
    report_and_stop(1);
  end
endmodule
